// ---- bench/rgm_mac_if_tb.sv ----
// self-checking bench: transmit, receive and management traffic against the phy model
`timescale 1ns/100ps
module rgm_mac_if_tb;
    localparam logic [4:0] PHY_A = 5'h03;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    rgm_pkg::rgm_speed_t speed = rgm_pkg::RGM_SPD_100;
    logic                tx_valid = 1'b0;
    logic                tx_err = 1'b0;
    logic [7:0]          tx_data = 8'h00;
    logic                mgmt_start = 1'b0;
    logic                mgmt_read = 1'b0;
    logic [4:0]          mgmt_phy = 5'h00;
    logic [4:0]          mgmt_reg = 5'h00;
    logic [15:0]         mgmt_wdata = 16'h0000;
    logic                mdc_on = 1'b0;
    logic                tx_ready, txc, tx_ctl, rxc, rx_ctl, rx_valid, rx_err, dv, er;
    logic                mgmt_busy, mgmt_done, mdc, mdio, mdio_out, mdio_oe, phy_oe, tx_stb, mdc_q;
    logic [3:0]          td, rd;
    logic [4:0]          ra;
    logic [7:0]          rx_data, tx_per, exp_per, b;
    logic [9:0]          tx_word;
    logic [15:0]         mgmt_rdata, got, wd;
    logic [9:0]          tx_q[$];
    logic [8:0]          rx_q[$];
    int                  fail_count = 0, n_compared = 0, tx_todo = 0, skip = 0, mdc_cnt = 0, n;
    rgm_pkg::rgm_speed_t spd_tab[3] = '{rgm_pkg::RGM_SPD_10, rgm_pkg::RGM_SPD_100, rgm_pkg::RGM_SPD_1000};
    // txc period in clocks: 2.5 MHz, 25 MHz, and 25 MHz standing in for 125 MHz
    logic [7:0]          per_tab[3] = '{8'h14, 8'h02, 8'h02};

    rgm_mac_if DUT (.clk, .rst_n, .speed, .tx_valid, .tx_data, .tx_err, .tx_ready, .txc, .td, .tx_ctl,
        .rxc, .rd, .rx_ctl, .rx_data, .rx_valid, .rx_err, .mgmt_start, .mgmt_read, .mgmt_phy, .mgmt_reg,
        .mgmt_wdata, .mgmt_busy, .mgmt_done, .mgmt_rdata, .mdc, .mdio_in(mdio), .mdio_out, .mdio_oe);
    rgm_phy_model #(.PHY_ADDR(PHY_A)) phy (.clk, .txc, .td, .tx_ctl, .rxc, .rd, .rx_ctl, .mdc,
        .mac_out(mdio_out), .mac_oe(mdio_oe), .mdio, .phy_oe, .tx_stb, .tx_word, .tx_per);

    always #10 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic mgmt(input logic rd_op, input logic [4:0] pa, input logic [4:0] rg,
                        input logic [15:0] wv, output logic [15:0] rv);
        @(posedge clk);
        mgmt_start <= 1'b1;
        mgmt_read  <= rd_op;
        mgmt_phy   <= pa;
        mgmt_reg   <= rg;
        mgmt_wdata <= wv;
        @(posedge clk);
        // further starts while busy must be ignored
        mgmt_reg   <= rg + 5'h01;
        mgmt_wdata <= ~wv;
        repeat (2) @(posedge clk);
        mgmt_start <= 1'b0;
        n = 0;
        while (mgmt_done !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        check("mgmt done", 16'(n < 2000), 16'h0001);
        rv = mgmt_rdata;
    endtask

    // ----------------------------------------
    // stimulus source and result monitors
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rst_n && tx_valid && tx_ready)
        begin
            tx_q.push_back({1'b1, tx_err, tx_data});
            tx_todo--;
        end
        if (rst_n && (!tx_valid || tx_ready))
        begin
            tx_valid <= (tx_todo > 0) && ($urandom % 4 != 0);
            tx_data  <= 8'($urandom);
            tx_err   <= ($urandom % 8 == 0);
        end
    end

    always @(posedge clk)
    begin
        if (tx_stb === 1'b1)
        begin
            if (skip > 0)
                skip--;
            else
                check("txc period", 16'(tx_per), 16'(exp_per));
            if (tx_word[9] !== 1'b1)
                check("tx idle", 16'(tx_word), 16'h0000);
            else
                check("tx byte", 16'(tx_word), 16'(tx_q.pop_front()));
        end
        if (rx_valid === 1'b1)
            check("rx byte", 16'({rx_err, rx_data}), 16'(rx_q.pop_front()));
        if (mdio_oe === 1'b1 && phy_oe === 1'b1)
            check("mdio both drive", 16'h0001, 16'h0000);
    end

    always @(posedge clk)
    begin
        mdc_q   <= mdc;
        mdc_cnt <= mdc_cnt + 1;
        if (mgmt_busy !== 1'b1)
            mdc_on <= 1'b0;
        if (mdc === 1'b1 && mdc_q === 1'b0)
        begin
            if (mdc_on === 1'b1)
                check("mdc period", 16'(mdc_cnt), 16'h0014);
            mdc_on  <= 1'b1;
            mdc_cnt <= 1;
        end
    end

    initial
    begin
        #1000000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(1));
        repeat (6) @(posedge clk);
        check("reset outs", 16'({txc, td, tx_ctl, mdc, mdio_oe, mgmt_busy, rx_valid}), 16'h0000);
        rst_n <= 1'b1;
        foreach (spd_tab[i])
        begin
            @(posedge clk);
            speed   <= spd_tab[i];
            exp_per <= per_tab[i];
            @(negedge clk);
            skip    = 3;
            tx_todo = 30;
            n = 0;
            while ((tx_todo > 0 || tx_q.size() > 0) && n < 5000)
            begin
                @(posedge clk);
                n++;
            end
            check("tx drained", 16'(n < 5000), 16'h0001);
            repeat (40) @(posedge clk);
        end
        check("tx left", 16'(tx_q.size()), 16'h0000);
        repeat (24)
        begin
            b  = 8'($urandom);
            dv = ($urandom % 4 != 0);
            er = ($urandom % 4 == 0);
            if (dv)
                rx_q.push_back({er, b});
            phy.send_rx(b, dv, er);
            repeat (3) @(posedge clk);
            check("rx err", 16'(rx_err), 16'(er));
        end
        phy.rx_end();
        repeat (10) @(posedge clk);
        check("rx left", 16'(rx_q.size()), 16'h0000);
        wd = 16'($urandom);
        ra = 5'($urandom);
        mgmt(1'b0, PHY_A, ra, wd, got);
        mgmt(1'b1, PHY_A, ra, 16'h0000, got);
        check("mgmt read", got, wd);
        mgmt(1'b1, PHY_A ^ 5'h01, ra, 16'h0000, got);
        check("mgmt no phy", got, 16'hFFFF);
        wrap_up();
    end
endmodule

// ---- bench/rgm_phy_model.sv ----
// phy partner model: captures transmit bytes, sources receive bytes, answers management frames
`timescale 1ns/100ps
module rgm_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input  wire logic       clk,
    input  wire logic       txc,
    input  wire logic [3:0] td,
    input  wire logic       tx_ctl,
    output logic            rxc,
    output logic [3:0]      rd,
    output logic            rx_ctl,
    input  wire logic       mdc,
    input  wire logic       mac_out,
    input  wire logic       mac_oe,
    output logic            mdio,
    output logic            phy_oe,
    output logic            tx_stb,
    output logic [9:0]      tx_word,
    output logic [7:0]      tx_per
);
    logic        txc_q;
    logic [4:0]  low;
    logic [7:0]  cnt;
    logic        phy_out;
    logic [15:0] regs [32];
    logic [5:0]  pos = 6'h00;
    logic [12:0] hdr;
    logic [15:0] sh;

    // ----------------------------------------
    // line, transmit capture, receive source, management slave
    // ----------------------------------------
    // pulled up when nobody drives the management line
    assign mdio = mac_oe ? mac_out : (phy_oe ? phy_out : 1'b1);

    initial
    begin
        rxc    = 1'b0;
        rd     = 4'h0;
        rx_ctl = 1'b0;
        phy_oe = 1'b0;
        foreach (regs[i]) regs[i] = 16'h0000;
    end

    // word is {enable, error, byte}
    always @(posedge clk)
    begin
        tx_stb <= 1'b0;
        txc_q  <= txc;
        cnt    <= cnt + 8'h01;
        if (txc && !txc_q)
        begin
            low    <= {tx_ctl, td};
            tx_per <= cnt;
            cnt    <= 8'h01;
        end
        if (!txc && txc_q)
        begin
            tx_stb  <= 1'b1;
            tx_word <= {low[4], tx_ctl, td, low[3:0]};
        end
    end

    // receive clock stands still between calls
    task automatic send_rx(input logic [7:0] b, input logic dv, input logic er);
        rd     <= b[3:0];
        rx_ctl <= dv;
        #20 rxc <= 1'b1;
        #60 rd <= b[7:4];
        rx_ctl <= er;
        #20 rxc <= 1'b0;
        #60;
    endtask

    // released data lines show the inverse of their last value
    task automatic rx_end();
        rd     <= ~rd;
        rx_ctl <= ~rx_ctl;
    endtask

    always @(posedge mdc)
    begin
        pos <= pos + 6'h01;
        sh  <= {sh[14:0], mdio};
        if (pos <= 6'h2D)
            hdr <= {hdr[11:0], mdio};
        if (pos == 6'h3F && hdr[11:10] == 2'h1 && hdr[9:5] == PHY_ADDR)
            regs[hdr[4:0]] <= {sh[14:0], mdio};
        if (pos == 6'h3F)
            phy_oe <= #100 1'b0;
    end

    always @(negedge mdc)
    begin
        if (pos >= 6'h2F && hdr[11:10] == 2'h2 && hdr[9:5] == PHY_ADDR)
        begin
            phy_oe  <= 1'b1;
            phy_out <= (pos == 6'h2F) ? 1'b0 : regs[hdr[4:0]][4'(6'h3F - pos)];
        end
    end
endmodule

// ---- rtl/rgm_mac_if.sv ----
// mac side reduced gigabit media independent interface: tx, rx and management
// Contract
// - fourteen pins, data valid on both edges
// - mac drives tx clock at speed rate; at 1000 the 50 MHz clock gives 25 MHz, not 125 MHz
// - tx bits 3:0 rising, 7:4 falling
// - tx control: enable rising, error falling
// - mac sources the management clock
// - management data line is bidirectional
`timescale 1ns/100ps
module rgm_mac_if (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire rgm_pkg::rgm_speed_t speed,
    input  wire logic                tx_valid,
    input  wire logic [7:0]          tx_data,
    input  wire logic                tx_err,
    output logic                     tx_ready,
    output logic                     txc,
    output logic [3:0]               td,
    output logic                     tx_ctl,
    input  wire logic                rxc,
    input  wire logic [3:0]          rd,
    input  wire logic                rx_ctl,
    output logic [7:0]               rx_data,
    output logic                     rx_valid,
    output logic                     rx_err,
    input  wire logic                mgmt_start,
    input  wire logic                mgmt_read,
    input  wire logic [4:0]          mgmt_phy,
    input  wire logic [4:0]          mgmt_reg,
    input  wire logic [15:0]         mgmt_wdata,
    output logic                     mgmt_busy,
    output logic                     mgmt_done,
    output logic [15:0]              mgmt_rdata,
    output logic                     mdc,
    input  wire logic                mdio_in,
    output logic                     mdio_out,
    output logic                     mdio_oe
);
    logic [rgm_pkg::DIV_W-1:0] tx_div;
    logic [rgm_pkg::DIV_W-1:0] half;
    logic                      tx_tick;
    logic [7:0]                tx_byte;
    logic                      tx_err_q;

    logic [2:0]                rxc_s;
    logic [3:0]                rd_s [3];
    logic [2:0]                ctl_s;
    logic                      rxc_lvl;
    logic                      rx_rise;
    logic                      rx_fall;
    logic [3:0]                rx_lo;
    logic                      rx_dv;

    rgm_mgmt_if mg ();

    // ------------------------------------------------------------
    // transmit clock divider
    // ------------------------------------------------------------
    assign half    = rgm_pkg::txc_half(speed);
    assign tx_tick = (tx_div >= half - 1'b1);
    // byte taken as the rising half begins
    assign tx_ready = tx_tick && !txc;

    always_ff @(posedge clk)
    begin
        if (!rst_n || tx_tick)
            tx_div <= '0;
        else
            tx_div <= tx_div + 1'b1;
    end

    // ------------------------------------------------------------
    // transmit pins, clock and data change together
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            txc      <= 1'b0;
            td       <= 4'h0;
            tx_ctl   <= 1'b0;
            tx_byte  <= 8'h00;
            tx_err_q <= 1'b0;
        end
        else if (tx_tick)
        begin
            txc <= !txc;
            if (!txc)
            begin
                tx_byte  <= tx_valid ? tx_data : 8'h00;
                tx_err_q <= tx_valid && tx_err;
                td       <= tx_valid ? tx_data[3:0] : 4'h0;
                tx_ctl   <= tx_valid;
            end
            else
            begin
                td     <= tx_byte[7:4];
                tx_ctl <= tx_err_q;
            end
        end
    end

    // ------------------------------------------------------------
    // receive synchronisers and edge finder
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rxc_s <= 3'h0;
            ctl_s <= 3'h0;
            rd_s  <= '{default: 4'h0};
        end
        else
        begin
            rxc_s <= {rxc_s[1:0], rxc};
            ctl_s <= {ctl_s[1:0], rx_ctl};
            rd_s  <= '{rd, rd_s[0], rd_s[1]};
        end
    end

    // edge counts once stages two and three agree
    assign rx_rise = (rxc_s[1] == rxc_s[2]) && rxc_s[2] && !rxc_lvl;
    assign rx_fall = (rxc_s[1] == rxc_s[2]) && !rxc_s[2] && rxc_lvl;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rxc_lvl <= 1'b0;
        else if (rx_rise || rx_fall)
            rxc_lvl <= rxc_s[2];
    end

    // ------------------------------------------------------------
    // receive byte assembly
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        rx_valid <= 1'b0;
        if (!rst_n)
        begin
            rx_lo   <= 4'h0;
            rx_dv   <= 1'b0;
            rx_data <= 8'h00;
            rx_err  <= 1'b0;
        end
        else if (rx_rise)
        begin
            rx_lo <= rd_s[2];
            rx_dv <= ctl_s[2];
        end
        else if (rx_fall)
        begin
            rx_data  <= {rd_s[2], rx_lo};
            rx_valid <= rx_dv;
            rx_err   <= ctl_s[2];
        end
    end

    // ------------------------------------------------------------
    // management engine
    // ------------------------------------------------------------
    assign mg.start   = mgmt_start;
    assign mg.read    = mgmt_read;
    assign mg.phy     = mgmt_phy;
    assign mg.regad   = mgmt_reg;
    assign mg.wdata   = mgmt_wdata;
    assign mgmt_busy  = mg.busy;
    assign mgmt_done  = mg.done;
    assign mgmt_rdata = mg.rdata;

    rgm_mdio_eng u_mdio (
        .clk      (clk),
        .rst_n    (rst_n),
        .m        (mg.eng),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [rgm_pkg::DIV_W-1:0] run;
    logic                      txc_q;
    logic                      spd_chg;
    rgm_pkg::rgm_speed_t       speed_q;

    localparam logic [rgm_pkg::DIV_W-1:0] DIV_W_ONE = 8'h01;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            run     <= '0;
            txc_q   <= 1'b0;
            spd_chg <= 1'b1;
            speed_q <= rgm_pkg::RGM_SPD_10;
        end
        else
        begin
            txc_q   <= txc;
            speed_q <= speed;
            run     <= (txc != txc_q) ? DIV_W_ONE : run + 1'b1;
            if (speed != speed_q)
                spd_chg <= 1'b1;
            else if (txc != txc_q)
                spd_chg <= 1'b0;
        end
    end
    property p_pin_pair;
        @(posedge clk) disable iff (!rst_n) tx_ready |=> txc;
    endproperty
    a_pin_pair: assert property (p_pin_pair) else $error("byte taken without rising tx clock");

    property p_tx_lo;
        @(posedge clk) disable iff (!rst_n)
            tx_ready && tx_valid |=> td == $past(tx_data[3:0]);
    endproperty
    a_tx_lo: assert property (p_tx_lo) else $error("low nibble not on rising edge");

    property p_tx_hi;
        @(posedge clk) disable iff (!rst_n) $fell(txc) |-> td == tx_byte[7:4];
    endproperty
    a_tx_hi: assert property (p_tx_hi) else $error("high nibble not on falling edge");

    property p_tx_en;
        @(posedge clk) disable iff (!rst_n) tx_ready |=> tx_ctl == $past(tx_valid);
    endproperty
    a_tx_en: assert property (p_tx_en) else $error("enable not on rising edge");

    property p_tx_er;
        @(posedge clk) disable iff (!rst_n) $fell(txc) |-> tx_ctl == tx_err_q;
    endproperty
    a_tx_er: assert property (p_tx_er) else $error("error not on falling edge");

    property p_txc_half;
        // the half period of the old speed may still end in the cycle after a change
        @(posedge clk) disable iff (!rst_n) txc != txc_q && !spd_chg && speed == speed_q |-> run == half;
    endproperty
    a_txc_half: assert property (p_txc_half) else $error("tx clock half period wrong");

    property p_txc_10;
        @(posedge clk) disable iff (!rst_n)
            txc != txc_q && !spd_chg && speed == speed_q && speed == rgm_pkg::RGM_SPD_10 |-> run == 8'hA;
    endproperty
    a_txc_10: assert property (p_txc_10) else $error("10 Mbps tx clock not 2.5 MHz");

    property p_rx_byte;
        @(posedge clk) disable iff (!rst_n)
            rx_fall && rx_dv |=> rx_valid && rx_data == {$past(rd_s[2]), $past(rx_lo)};
    endproperty
    a_rx_byte: assert property (p_rx_byte) else $error("receive byte misassembled");

    property p_rx_flags;
        @(posedge clk) disable iff (!rst_n) rx_fall |=> rx_valid == $past(rx_dv) && rx_err == $past(ctl_s[2]);
    endproperty
    a_rx_flags: assert property (p_rx_flags) else $error("receive control misdecoded");

    property p_rx_edge;
        @(posedge clk) disable iff (!rst_n) rx_rise |-> ##1 !rx_rise;
    endproperty
    a_rx_edge: assert property (p_rx_edge) else $error("receive edge counted twice");

    c_tx_frame: cover property (@(posedge clk) disable iff (!rst_n) tx_ready && tx_valid ##1 tx_ctl);
    c_tx_err:   cover property (@(posedge clk) disable iff (!rst_n) $fell(txc) && tx_ctl);
    c_rx_byte:  cover property (@(posedge clk) disable iff (!rst_n) rx_valid && !rx_err);
endmodule

// ---- rtl/rgm_mdio_eng.sv ----
// management clock generator and serial frame engine
`timescale 1ns/100ps
module rgm_mdio_eng (
    input  wire logic  clk,
    input  wire logic  rst_n,
    rgm_mgmt_if.eng    m,
    output logic       mdc,
    input  wire logic  mdio_in,
    output logic       mdio_out,
    output logic       mdio_oe
);
    localparam logic [rgm_pkg::DIV_W-1:0] HALF = rgm_pkg::half_cycles(rgm_pkg::MDC_HALF_NS);

    logic [rgm_pkg::DIV_W-1:0] div;
    logic [5:0]                cnt;
    logic [31:0]               frame;
    logic                      rd_op;
    logic [2:0]                din_s;
    logic                      din_lvl;
    logic                      tick;

    assign tick = (div >= HALF - 1'b1);

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            din_s   <= 3'h7;
            din_lvl <= 1'b1;
        end
        else
        begin
            din_s <= {din_s[1:0], mdio_in};
            // a change counts once stages two and three agree
            if (din_s[1] == din_s[2])
                din_lvl <= din_s[2];
        end
    end

    // ------------------------------------------------------------
    // clock divider, runs only during a frame
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || !m.busy || tick)
            div <= '0;
        else
            div <= div + 1'b1;
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        m.done <= 1'b0;
        if (!rst_n)
        begin
            m.busy   <= 1'b0;
            mdc      <= 1'b0;
            cnt      <= '0;
            frame    <= '0;
            rd_op    <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe  <= 1'b0;
            m.rdata  <= '0;
        end
        else if (!m.busy)
        begin
            if (m.start)
            begin
                m.busy   <= 1'b1;
                cnt      <= '0;
                rd_op    <= m.read;
                frame    <= {rgm_pkg::MDIO_START, m.read ? rgm_pkg::MDIO_OP_READ : rgm_pkg::MDIO_OP_WRITE,
                             m.phy, m.regad, rgm_pkg::MDIO_TA_WRITE, m.wdata};
                mdio_out <= 1'b1;
                mdio_oe  <= 1'b1;
            end
        end
        else if (tick)
        begin
            mdc <= !mdc;
            if (!mdc)
            begin
                // phy drives read data, sampled on the rising edge
                if (rd_op && cnt >= 6'(rgm_pkg::MDIO_DATA_FIRST))
                    m.rdata <= {m.rdata[14:0], din_lvl};
            end
            else if (cnt == 6'(rgm_pkg::MDIO_FRAME_BITS - 1))
            begin
                m.busy  <= 1'b0;
                m.done  <= 1'b1;
                mdio_oe <= 1'b0;
            end
            else
            begin
                cnt <= cnt + 1'b1;
                if (cnt + 1'b1 >= 6'(rgm_pkg::MDIO_PREAMBLE))
                begin
                    mdio_out <= frame[31];
                    frame    <= {frame[30:0], 1'b0};
                end
                // release the line to the phy from the turnaround on a read
                mdio_oe <= !(rd_op && cnt + 1'b1 >= 6'(rgm_pkg::MDIO_RELEASE_BIT));
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_mdc_idle;
        @(posedge clk) disable iff (!rst_n) !m.busy |-> !mdc;
    endproperty
    a_mdc_idle: assert property (p_mdc_idle) else $error("mdc toggles outside a frame");

    property p_read_release;
        @(posedge clk) disable iff (!rst_n)
            m.busy && rd_op && cnt >= 6'(rgm_pkg::MDIO_RELEASE_BIT) |-> !mdio_oe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("mac drives mdio in read phase");

    property p_write_drive;
        @(posedge clk) disable iff (!rst_n) m.busy && !rd_op |-> mdio_oe;
    endproperty
    a_write_drive: assert property (p_write_drive) else $error("mac released mdio during write");

    c_read_done: cover property (@(posedge clk) disable iff (!rst_n) m.done && rd_op);
endmodule

// ---- rtl/rgm_mgmt_if.sv ----
// request and answer signals between the core and the management engine
`timescale 1ns/100ps
interface rgm_mgmt_if;
    logic        start;
    logic        read;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
    logic        busy;
    logic        done;
    logic [15:0] rdata;

    modport ctrl (output start, read, phy, regad, wdata, input busy, done, rdata);
    modport eng  (input start, read, phy, regad, wdata, output busy, done, rdata);
endinterface

// ---- rtl/rgm_pkg.sv ----
// constants, speed codes and helpers shared by the reduced gigabit interface block
package rgm_pkg;

    typedef enum logic [1:0] {RGM_SPD_10, RGM_SPD_100, RGM_SPD_1000} rgm_speed_t;

    localparam int unsigned CLK_PERIOD_NS      = 20;
    // half periods of the forwarded transmit clock: 2.5, 25 and 125 MHz
    localparam int unsigned TXC_HALF_10_NS     = 200;
    localparam int unsigned TXC_HALF_100_NS    = 20;
    localparam int unsigned TXC_HALF_1000_NS   = 4;
    // management clock half period, 2.5 MHz
    localparam int unsigned MDC_HALF_NS        = 200;

    localparam int unsigned DIV_W              = 8;
    localparam int unsigned SYNC_STAGES        = 3;

    // management frame layout
    localparam int unsigned MDIO_PREAMBLE      = 32;
    localparam int unsigned MDIO_FRAME_BITS    = 64;
    localparam int unsigned MDIO_RELEASE_BIT   = 46;
    localparam int unsigned MDIO_DATA_FIRST    = 48;
    localparam logic [1:0]  MDIO_START         = 2'h1;
    localparam logic [1:0]  MDIO_OP_READ       = 2'h2;
    localparam logic [1:0]  MDIO_OP_WRITE      = 2'h1;
    localparam logic [1:0]  MDIO_TA_WRITE      = 2'h2;

    // longest time: round down, never below one cycle
    function automatic logic [DIV_W-1:0] half_cycles(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        half_cycles = DIV_W'(c);
    endfunction

    function automatic logic [DIV_W-1:0] txc_half(input rgm_speed_t spd);
        unique case (spd)
            RGM_SPD_10:   txc_half = half_cycles(TXC_HALF_10_NS);
            RGM_SPD_100:  txc_half = half_cycles(TXC_HALF_100_NS);
            RGM_SPD_1000: txc_half = half_cycles(TXC_HALF_1000_NS);
            default:      txc_half = half_cycles(TXC_HALF_10_NS);
        endcase
    endfunction

endpackage
